// File: include/acs_params.svh
// Constants of the conversion sequencer: offsets, fields, resets, timing.
// Assumes a 125 MHz system clock; included by the package and the core.
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ==========================================================
// Clock and sizes
`define ACS_CLK_MHZ 125
`define ACS_CHANNELS 8
`define ACS_RES_W 16

// ==========================================================
// Register offsets (result words: low byte even, high byte odd)
`define ACS_OFS_CTRL 8'h15
`define ACS_OFS_DIS 8'h16
`define ACS_OFS_STAT 8'h17
`define ACS_OFS_RES 8'h18
`define ACS_RES_LAST 8'h27

// ==========================================================
// Field positions and reset values
`define ACS_CTRL_RUN 7
`define ACS_CTRL_RATE 6
`define ACS_CTRL_SMP 4
`define ACS_STAT_DONE 0
`define ACS_STAT_FLAG 1
`define ACS_STAT_MASK 2
`define ACS_CTRL_RST 8'h00
`define ACS_DIS_RST 8'h00
`define ACS_STAT_RST 8'h00

// ==========================================================
// Timing: figures in ns, counts rounded to whole cycles
`define ACS_IRQ_PULSE_NS 256000
`define ACS_IRQ_CYC ((`ACS_IRQ_PULSE_NS * `ACS_CLK_MHZ) / 1000)
`define ACS_SETTLE_NS 1000
`define ACS_SETTLE_CYC ((`ACS_SETTLE_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_CONV0_NS 8000
`define ACS_CONV1_NS 16000
`define ACS_CONV2_NS 24000
`define ACS_CONV3_NS 32000
`define ACS_CONV_CYC(ns) (((ns) * `ACS_CLK_MHZ + 999) / 1000)

`endif

// File: include/acs_pkg.sv
// Types shared by the conversion sequencer files.
// Assumes acs_params.svh is on the include path.
`include "acs_params.svh"

package acs_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ACS_IDLE = 3'b001,
    ACS_CONV = 3'b010,
    ACS_PAUSE = 3'b100
  } acs_fsm_t;

  // Byte register request from the serial port front end
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acs_reg_req_t;

  // Byte register answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } acs_reg_rsp_t;

  // Charger level inputs, asynchronous to sys_clk
  typedef struct packed {
    logic battery_valid_level;
    logic input_valid_low_level;
    logic input_overvoltage_level;
    logic otg_output_enable;
    logic input_high_impedance_enable;
    logic adapter_present;
    logic source_detect_done;
    logic mode_change_busy;
  } acs_pins_t;

  // Whole state of the sequencer
  typedef struct packed {
    acs_fsm_t fsm;
    logic run;
    logic oneshot;
    logic [1:0] smp;
    logic [7:0] dis;
    logic done_stat;
    logic done_flag;
    logic done_mask;
    logic [2:0] chan;
    logic [11:0] timer;
    logic [11:0] settle;
    logic [15:0] irq_cnt;
    logic irq_n;
    logic active;
    logic sample_stb;
    logic prev_otg;
    logic prev_hiz;
    logic mem_we;
    logic [2:0] mem_addr;
    logic [15:0] mem_wdata;
    logic rd_pend;
    logic rd_mem;
    logic rd_hi;
    logic [7:0] loc_data;
    acs_reg_rsp_t rsp;
    acs_pins_t s1;
    acs_pins_t s2;
  } acs_state_t;

endpackage

// File: core/acs_result_mem.sv
// Result store: one word per channel, whole-word writes, registered read.
// Assumes write and read requests come from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module acs_result_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic we, // Write whole word
  input wire logic [$clog2(DEPTH)-1:0] waddr, // Write index
  input wire logic [WIDTH-1:0] wdata, // Write word
  input wire logic [$clog2(DEPTH)-1:0] raddr, // Read index
  output logic [WIDTH-1:0] rdata // Registered read word
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================
  // Entries: reset to zero, written only as whole words
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          mem[i] <= '0;
        end else if (ce && we && waddr == i) begin
          mem[i] <= wdata;
        end
      end
    end
  endgenerate

  // Read port register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end

endmodule

`default_nettype wire

// File: core/acs_sequencer.sv
// Measurement converter sequencer with its control and result registers.
// Assumes a serial port front end on sys_clk turning bus traffic into byte
// requests, a converter whose result adc_data is on sys_clk, and charger
// level inputs that are asynchronous.
`timescale 1ns/1ps
`default_nettype none

`include "acs_params.svh"

// How it works
// - Results are 16 bits; run bit turns all conversion on or off.
// - Rate bit picks continuous (0) or one-shot (1) operation.
// - One-shot clears run itself at cycle end; setting run again restarts.
// - No valid supply: no conversion, results kept, run cleared, no pulse.
// - One-shot with every channel disabled clears run itself.
// - Continuous keeps the converter active while run is set, channels or not.
// - Mode change pauses conversion; resumes on the interrupted channel.
// - Two-bit sample field sets each conversion's duration.
// - Channel disable register resets to zero: all channels converted.
// - A channel disabled before its turn keeps its old result.
// - Disable during a channel finishes it, skips it from then on.
// - Clearing any disable bit while enabled restarts conversion promptly.
// - Continuous holds done status low; one-shot end sets status and flag.
// - Writing run to zero stops at once; results keep last values.
// - All channels disabled: stop after the channel in progress.
// - Rate set to one-shot mid-run: stop after the current cycle.
// - Adapter attach suspends conversion until source detection finishes.
// - Faults do not disturb conversion while the battery is valid.
// - Unmasked event gives a 256 us low pulse on the interrupt pin.
// - Masked event is still recorded but gives no pulse.
// - Reading the flag clears it; a new status rise sets it again.
module acs_sequencer #(
  parameter int IRQ_PULSE_CYC = `ACS_IRQ_CYC
) (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable, freezes all state
  input wire acs_pkg::acs_reg_req_t reg_req, // Byte register request
  output acs_pkg::acs_reg_rsp_t reg_rsp, // Byte read answer
  input wire acs_pkg::acs_pins_t pins, // Charger levels
  input wire logic [15:0] adc_data, // Converter result
  output logic adc_active, // Converter powered
  output logic [2:0] adc_channel, // Channel being converted
  output logic adc_sample, // Result taken this cycle
  output logic host_interrupt_n // Interrupt pulse, low
);
  import acs_pkg::*;

  localparam acs_state_t ST_RST = '{
    fsm: ACS_IDLE,
    irq_n: 1'b1,
    dis: `ACS_DIS_RST,
    default: '0
  };

  generate
    if (IRQ_PULSE_CYC < 1 || IRQ_PULSE_CYC > 65535) begin : g_chk
      $error("IRQ_PULSE_CYC must lie in 1..65535");
    end
  endgenerate

  acs_state_t r;
  acs_state_t n;
  acs_pins_t p;
  logic supply_ok;
  logic otg_rise;
  logic hiz_rise;
  logic hold;
  logic cyc_end;
  logic done_evt;
  logic [7:0] en;
  logic [3:0] first_ch;
  logic [3:0] next_ch;
  logic [15:0] mem_q;
  logic [2:0] mem_raddr;
  logic res_hit;

  // ==========================================================
  // Helpers
  // Lowest enabled channel at or above from; bit 3 set when none
  function automatic logic [3:0] pick(input logic [7:0] m, input logic [3:0] from);
    logic [3:0] res;
    res = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (m[i] && i >= from) begin
        res = {1'b0, 3'(i)};
      end
    end
    return res;
  endfunction

  // Cycles of one conversion for a sample field value
  function automatic logic [11:0] conv_cyc(input logic [1:0] s);
    logic [11:0] c;
    c = 12'(`ACS_CONV_CYC(`ACS_CONV0_NS));
    unique case (s)
      2'h0: c = 12'(`ACS_CONV_CYC(`ACS_CONV0_NS));
      2'h1: c = 12'(`ACS_CONV_CYC(`ACS_CONV1_NS));
      2'h2: c = 12'(`ACS_CONV_CYC(`ACS_CONV2_NS));
      2'h3: c = 12'(`ACS_CONV_CYC(`ACS_CONV3_NS));
    endcase
    return c;
  endfunction

  // ==========================================================
  // Derived conditions from synchronised levels
  assign p = r.s2;
  assign supply_ok = p.battery_valid_level |
                     (p.input_valid_low_level & ~p.input_overvoltage_level);
  assign otg_rise = p.otg_output_enable & ~r.prev_otg;
  assign hiz_rise = p.input_high_impedance_enable & ~r.prev_hiz;
  // Any mode change or adapter detection in progress
  assign hold = otg_rise | hiz_rise | (r.settle != 12'h000) | p.mode_change_busy |
                (p.adapter_present & ~p.source_detect_done);
  assign en = ~r.dis;
  assign first_ch = pick(en, 4'h0);
  assign next_ch = pick(en, {1'b0, r.chan} + 4'h1);
  assign res_hit = reg_req.addr >= `ACS_OFS_RES && reg_req.addr <= `ACS_RES_LAST;
  assign mem_raddr = 3'((reg_req.addr - `ACS_OFS_RES) >> 1);

  // Result words
  acs_result_mem #(
    .DEPTH(`ACS_CHANNELS),
    .WIDTH(`ACS_RES_W)
  ) u_mem (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .we(r.mem_we),
    .waddr(r.mem_addr),
    .wdata(r.mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_q)
  );

  // ==========================================================
  // Next state
  always_comb begin
    n = r;
    n.sample_stb = 1'b0;
    n.mem_we = 1'b0;
    n.rsp.valid = 1'b0;
    n.rd_pend = 1'b0;
    cyc_end = 1'b0;
    // Two-stage synchroniser on charger levels
    n.s1 = pins;
    n.s2 = r.s1;
    n.prev_otg = p.otg_output_enable;
    n.prev_hiz = p.input_high_impedance_enable;
    // Settling window after OTG or high impedance turns on
    if (otg_rise || hiz_rise) begin
      n.settle = 12'(`ACS_SETTLE_CYC);
    end else if (r.settle != 12'h000) begin
      n.settle = r.settle - 12'h001;
    end

    // Sequencer
    unique case (r.fsm)
      ACS_IDLE: begin
        n.active = 1'b0;
        if (r.run) begin
          if (!supply_ok) begin
            n.run = 1'b0;
          end else if (en == 8'h00) begin
            if (r.oneshot) begin
              n.run = 1'b0;
            end else begin
              n.active = 1'b1;
            end
          end else if (!hold) begin
            // Start a cycle at the lowest enabled channel
            n.active = 1'b1;
            n.chan = first_ch[2:0];
            n.timer = conv_cyc(r.smp);
            n.done_stat = 1'b0;
            n.fsm = ACS_CONV;
          end
        end
      end
      ACS_CONV: begin
        if (!r.run) begin
          n.fsm = ACS_IDLE;
          n.active = 1'b0;
        end else if (!supply_ok) begin
          n.run = 1'b0;
          n.active = 1'b0;
          n.fsm = ACS_IDLE;
        end else if (hold) begin
          n.active = 1'b0;
          n.fsm = ACS_PAUSE;
        end else if (r.timer > 12'h001) begin
          n.timer = r.timer - 12'h001;
        end else begin
          // Channel finished even if disabled meanwhile
          n.mem_we = 1'b1;
          n.mem_addr = r.chan;
          n.mem_wdata = adc_data;
          n.sample_stb = 1'b1;
          if (!next_ch[3]) begin
            n.chan = next_ch[2:0];
            n.timer = conv_cyc(r.smp);
          end else begin
            cyc_end = 1'b1;
            if (r.oneshot) begin
              n.run = 1'b0;
              n.done_stat = 1'b1;
              n.active = 1'b0;
              n.fsm = ACS_IDLE;
            end else if (!first_ch[3]) begin
              n.chan = first_ch[2:0];
              n.timer = conv_cyc(r.smp);
            end else begin
              n.fsm = ACS_IDLE;
            end
          end
        end
      end
      ACS_PAUSE: begin
        if (!r.run) begin
          n.fsm = ACS_IDLE;
        end else if (!supply_ok) begin
          n.run = 1'b0;
          n.fsm = ACS_IDLE;
        end else if (!hold) begin
          // Resume the interrupted channel from its start
          n.active = 1'b1;
          n.timer = conv_cyc(r.smp);
          n.fsm = ACS_CONV;
        end
      end
      default: begin
        n.fsm = ACS_IDLE;
      end
    endcase
    if (!r.oneshot) begin
      n.done_stat = 1'b0;
    end

    // Done event: flag read clears, a rise of status sets and wins
    done_evt = n.done_stat & ~r.done_stat;
    if (reg_req.rd && reg_req.addr == `ACS_OFS_STAT) begin
      n.done_flag = 1'b0;
    end
    if (done_evt) begin
      n.done_flag = 1'b1;
    end
    // Interrupt pulse timer
    if (done_evt && !r.done_mask) begin
      n.irq_cnt = 16'(IRQ_PULSE_CYC);
    end else if (r.irq_cnt != 16'h0000) begin
      n.irq_cnt = r.irq_cnt - 16'h0001;
    end
    n.irq_n = n.irq_cnt == 16'h0000;

    // Register writes; a write of run wins over the automatic clear
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `ACS_OFS_CTRL: begin
          n.run = reg_req.wdata[`ACS_CTRL_RUN];
          n.oneshot = reg_req.wdata[`ACS_CTRL_RATE];
          n.smp = reg_req.wdata[`ACS_CTRL_SMP +: 2];
        end
        `ACS_OFS_DIS: begin
          n.dis = reg_req.wdata;
        end
        `ACS_OFS_STAT: begin
          n.done_mask = reg_req.wdata[`ACS_STAT_MASK];
        end
        default: begin
        end
      endcase
    end

    // Register reads: answer two cycles after the request
    if (reg_req.rd) begin
      n.rd_pend = 1'b1;
      n.rd_mem = res_hit;
      n.rd_hi = reg_req.addr[0];
      n.loc_data = 8'h00;
      unique case (reg_req.addr)
        `ACS_OFS_CTRL: begin
          n.loc_data[`ACS_CTRL_RUN] = r.run;
          n.loc_data[`ACS_CTRL_RATE] = r.oneshot;
          n.loc_data[`ACS_CTRL_SMP +: 2] = r.smp;
        end
        `ACS_OFS_DIS: begin
          n.loc_data = r.dis;
        end
        `ACS_OFS_STAT: begin
          n.loc_data[`ACS_STAT_DONE] = r.done_stat;
          n.loc_data[`ACS_STAT_FLAG] = r.done_flag;
          n.loc_data[`ACS_STAT_MASK] = r.done_mask;
        end
        default: begin
        end
      endcase
    end
    if (r.rd_pend) begin
      n.rsp.valid = 1'b1;
      n.rsp.data = r.rd_mem ? (r.rd_hi ? mem_q[15:8] : mem_q[7:0]) : r.loc_data;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r <= ST_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  // Outputs straight from state
  assign reg_rsp = r.rsp;
  assign adc_active = r.active;
  assign adc_channel = r.chan;
  assign adc_sample = r.sample_stb;
  assign host_interrupt_n = r.irq_n;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !ce);

  wire ctrl_wr = reg_req.wr && reg_req.addr == `ACS_OFS_CTRL;

  a_supply_drop_run: assert property (
    r.fsm == ACS_IDLE && r.run && !supply_ok && !ctrl_wr
    |=> !r.run && !$rose(r.done_flag) && !$fell(host_interrupt_n))
    else $error("run kept without valid supply");
  a_oneshot_empty_stop: assert property (
    r.fsm == ACS_IDLE && r.run && r.oneshot && supply_ok && en == 8'h00 && !ctrl_wr
    |=> !r.run && !$fell(host_interrupt_n))
    else $error("one-shot with no channel kept running");
  a_cont_stays_on: assert property (
    r.fsm == ACS_IDLE && r.run && !r.oneshot && supply_ok && en == 8'h00 && !ctrl_wr
    |=> adc_active && r.run)
    else $error("continuous converter went idle");
  a_oneshot_cycle_end: assert property (
    cyc_end && r.oneshot && !ctrl_wr |=> !r.run && r.done_stat && r.done_flag ##1 r.fsm == ACS_IDLE)
    else $error("one-shot did not finish");
  a_cont_done_low: assert property (
    !r.oneshot ##1 !r.oneshot |-> !r.done_stat)
    else $error("done status set in continuous mode");
  a_stop_at_once: assert property (
    ctrl_wr && !reg_req.wdata[`ACS_CTRL_RUN] |=> !r.run ##1 (r.fsm == ACS_IDLE && !r.mem_we))
    else $error("conversion not stopped by run clear");
  a_start_enabled_chan: assert property (
    r.fsm == ACS_IDLE && n.fsm == ACS_CONV |=> en[$past(first_ch[2:0])] && adc_channel == $past(first_ch[2:0]))
    else $error("cycle started on a disabled channel");
  a_pause_keeps_chan: assert property (
    r.fsm == ACS_PAUSE |=> $stable(adc_channel) && !adc_sample)
    else $error("channel moved during pause");
  a_ascending_order: assert property (
    adc_sample && r.fsm == ACS_CONV && !$past(cyc_end) |-> r.chan > r.mem_addr)
    else $error("channels not visited in ascending order");
  a_irq_pulse_len: assert property (
    $fell(host_interrupt_n) |-> r.irq_cnt == 16'(IRQ_PULSE_CYC))
    else $error("interrupt pulse length wrong");
  a_irq_end_high: assert property (
    r.irq_cnt == 16'h0001 && !done_evt |=> host_interrupt_n)
    else $error("interrupt pulse did not end");
  a_mask_no_pulse: assert property (
    done_evt && r.done_mask && r.irq_cnt == 16'h0000 |=> host_interrupt_n && r.done_flag)
    else $error("masked event pulsed or was lost");
  a_flag_read_clear: assert property (
    reg_req.rd && reg_req.addr == `ACS_OFS_STAT && !done_evt |=> !r.done_flag)
    else $error("flag survived a read");

  c_oneshot_done: cover property (cyc_end && r.oneshot ##1 !host_interrupt_n);
  c_pause_resume: cover property (r.fsm == ACS_PAUSE ##1 r.fsm == ACS_CONV);
  c_cont_wrap: cover property (cyc_end && !r.oneshot ##1 r.fsm == ACS_CONV);
  c_supply_lost: cover property (r.fsm == ACS_CONV && !supply_ok && r.run);

endmodule

`default_nettype wire

// File: sim/acs_adc_model.sv
// Converter stand-in facing the sequencer's conversion link.
// Assumes adc_active and adc_channel come from the sequencer on sys_clk.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Converter model
module acs_adc_model (
  input wire logic sys_clk, // System clock
  input wire logic [2:0] adc_channel, // Channel selected
  input wire logic adc_active, // Converter powered
  output logic [15:0] adc_data // Result word
);
  logic [15:0] junk_reg = 16'h1234;

  // Unpowered output wanders every cycle so stale data never looks valid
  always_ff @(posedge sys_clk) begin
    junk_reg <= ~junk_reg + 16'h3B1D;
  end

  // Powered word tags the channel being converted
  assign adc_data = adc_active ? {5'h14, adc_channel, 8'h5C} : junk_reg;
endmodule

`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the conversion sequencer.
// Assumes acs_pkg compiled first and acs_params.svh on the include path.
`timescale 1ns/1ps
`default_nettype none

`include "acs_params.svh"

// ==========================================================
// Bench top
module tb;
  import acs_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} acs_row_t;
  logic sys_clk;
  logic rst;
  logic ce;
  acs_reg_req_t reg_req;
  acs_reg_rsp_t reg_rsp;
  acs_pins_t pins;
  logic [15:0] adc_data;
  logic adc_active;
  logic adc_sample;
  logic host_interrupt_n;
  logic [2:0] adc_channel;
  logic [7:0] rb;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int irq_low = 0;
  int irq0;
  int n;
  acs_row_t rows [15];

  acs_sequencer #(.IRQ_PULSE_CYC(8)) i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .pins(pins), .adc_data(adc_data), .adc_active(adc_active), .adc_channel(adc_channel),
    .adc_sample(adc_sample), .host_interrupt_n(host_interrupt_n));
  acs_adc_model i_adc (.sys_clk(sys_clk), .adc_channel(adc_channel), .adc_active(adc_active), .adc_data(adc_data));

  // Clock at 125 MHz
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Interrupt low-time tally and hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (host_interrupt_n === 1'b0) irq_low++;
    if (cycles >= 60000) begin
      n_mismatch++;
      complete_run;
    end
  end

  // ==========================================================
  // Tasks
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
  endtask

  // Read answer stands from the first to the second edge after the request edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    reg_req.rd = 1'b0;
    @(negedge sys_clk);
    chk_val(reg_rsp.valid, 1'b1);
    d = reg_rsp.data;
  endtask

  // Waits for active (sel 0) or sample (sel 1), counting edges
  task automatic wait_for(input int sel, output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (((sel == 0) ? adc_active : adc_sample) !== 1'b1 && k < 9000);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd(a, rb);
    chk_val(rb, e);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rows = '{'{1'b0, 8'h15, 8'h00, 8'h00}, '{1'b0, 8'h16, 8'h00, 8'h00}, '{1'b0, 8'h17, 8'h00, 8'h00},
      '{1'b0, 8'h18, 8'h00, 8'h00}, '{1'b0, 8'h27, 8'h00, 8'h00}, '{1'b0, 8'h30, 8'h00, 8'h00},
      '{1'b1, 8'h30, 8'h55, 8'h00}, '{1'b0, 8'h30, 8'h00, 8'h00}, '{1'b1, 8'h17, 8'hFF, 8'h00},
      '{1'b0, 8'h17, 8'h00, 8'h04}, '{1'b1, 8'h17, 8'h00, 8'h00}, '{1'b1, 8'h16, 8'hFE, 8'h00},
      '{1'b0, 8'h16, 8'h00, 8'hFE}, '{1'b1, 8'h18, 8'h12, 8'h00}, '{1'b0, 8'h18, 8'h00, 8'h00}};
    rst = 1'b1;
    ce = 1'b1;
    reg_req = '0;
    pins = 8'hC2; // Battery and input valid, source detection done
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk_val({adc_active, host_interrupt_n}, 2'b01);
    // Register table: reset values, read-only and unmapped places
    for (int i = 0; i < 15; i++) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd_chk(rows[i].a, rows[i].e);
    end
    // One-shot on channel 0 at each sample speed
    for (int s = 0; s < 4; s++) begin
      wr(8'h15, 8'hC0 | 8'(s << 4));
      wait_for(0, n);
      wait_for(1, n);
      chk_val(n, `ACS_CONV_CYC(`ACS_CONV0_NS * (s + 1)));
      repeat (4) @(posedge sys_clk);
      rd_chk(8'h15, 8'h40 | 8'(s << 4));
      rd_chk(8'h18, 8'h5C);
      rd_chk(8'h19, 8'hA0);
    end
    repeat (20) @(negedge sys_clk);
    chk_val(irq_low, 32);
    rd_chk(8'h17, 8'h03);
    rd_chk(8'h17, 8'h01);
    // Masked one-shot over channels 0 and 2
    wr(8'h17, 8'h04);
    wr(8'h16, 8'hFA);
    irq0 = irq_low;
    wr(8'h15, 8'hC0);
    wait_for(1, n);
    repeat (5) @(negedge sys_clk);
    chk_val(adc_channel, 3'h2);
    wait_for(1, n);
    repeat (20) @(posedge sys_clk);
    rd_chk(8'h1C, 8'h5C);
    rd_chk(8'h1D, 8'hA2);
    rd_chk(8'h1A, 8'h00);
    rd_chk(8'h17, 8'h07);
    chk_val(irq_low, irq0);
    wr(8'h17, 8'h00);
    // One-shot with every channel disabled
    wr(8'h16, 8'hFF);
    wr(8'h15, 8'hC0);
    repeat (6) @(posedge sys_clk);
    rd_chk(8'h15, 8'h40);
    chk_val(adc_active, 1'b0);
    // No valid supply
    pins = 8'h02;
    wr(8'h16, 8'h00);
    repeat (5) @(negedge sys_clk);
    irq0 = irq_low;
    wr(8'h15, 8'hC0);
    repeat (10) @(posedge sys_clk);
    rd_chk(8'h15, 8'h40);
    rd_chk(8'h18, 8'h5C);
    chk_val(irq_low, irq0);
    // Continuous on channel 2 with a fault level present
    pins = 8'hE2;
    wr(8'h16, 8'hFB);
    wr(8'h15, 8'h80);
    wait_for(0, n);
    repeat (300) @(posedge sys_clk);
    for (int h = 0; h < 2; h++) begin
      @(negedge sys_clk);
      if (h == 0) pins.mode_change_busy = 1'b1;
      else pins.source_detect_done = 1'b0;
      pins.adapter_present = (h == 1);
      repeat (6) @(negedge sys_clk);
      chk_val({adc_active, adc_channel}, 4'h2);
      pins.mode_change_busy = 1'b0;
      pins.source_detect_done = 1'b1;
      wait_for(0, n);
      chk_val(n < 20 && adc_channel === 3'h2, 1'b1);
      repeat (100) @(posedge sys_clk);
    end
    rd_chk(8'h17, 8'h00);
    // All disabled mid-cycle, then one channel back
    wr(8'h16, 8'hFF);
    wait_for(1, n);
    chk_val(n <= 1000, 1'b1);
    repeat (10) @(negedge sys_clk);
    chk_val(adc_active, 1'b1);
    wr(8'h16, 8'hFB);
    wait_for(1, n);
    chk_val(n <= 1020, 1'b1);
    // Stop by clearing run
    repeat (200) @(posedge sys_clk);
    wr(8'h15, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk_val(adc_active, 1'b0);
    rd_chk(8'h1C, 8'h5C);
    // Rate switched to one-shot mid-run
    wr(8'h15, 8'h80);
    repeat (200) @(posedge sys_clk);
    wr(8'h15, 8'hC0);
    wait_for(1, n);
    chk_val(n <= 1000, 1'b1);
    repeat (4) @(posedge sys_clk);
    rd_chk(8'h15, 8'h40);
    // Clock enable low for 50 cycles freezes the conversion timer
    wr(8'h15, 8'h80);
    wait_for(0, n);
    @(negedge sys_clk);
    ce = 1'b0;
    repeat (50) @(negedge sys_clk);
    ce = 1'b1;
    wait_for(1, n);
    chk_val(n, `ACS_CONV_CYC(`ACS_CONV0_NS));
    // Reset in mid-run brings back the reset values
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    chk_val({adc_active, host_interrupt_n}, 2'b01);
    rd_chk(8'h15, 8'h00);
    rd_chk(8'h16, 8'h00);
    rd_chk(8'h1C, 8'h00);
    complete_run;
  end
endmodule

`default_nettype wire
